// ---- common/nfh_pkg.sv ----
package nfh_pkg;
  // Clock
  localparam int unsigned CLK_PERIOD_NS = 25;

  // Pin timing figures in ns
  localparam int unsigned WE_PULSE_NS       = 25;
  localparam int unsigned WE_HIGH_NS        = 15;
  localparam int unsigned OS_PULSE_NS       = 30;
  localparam int unsigned OS_HIGH_NS        = 15;
  localparam int unsigned OS_ACCESS_NS      = 35;
  localparam int unsigned WE_HIGH_TO_OS_NS  = 60;
  localparam int unsigned DESELECT_HOLD_NS  = 100;
  localparam int unsigned LAST_READ_BUSY_NS = 100;
  localparam int unsigned WE_TO_BUSY_NS     = 100;

  // Least times round up
  localparam int unsigned WE_LOW_CYC  = (WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WE_HIGH_CYC = (WE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned OS_LOW_CYC  = (OS_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned OS_HIGH_CYC = (OS_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WHR_CYC     = (WE_HIGH_TO_OS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CEH_CYC     = (DESELECT_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Wait for busy to show before trusting ready
  localparam int unsigned BUSY_WAIT_CYC = (WE_TO_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 2;

  // Longest device times in us; all but RESET_READ_US and RESET_PROGRAM_US serve as timeout defaults
  localparam int unsigned ARRAY_FETCH_US     = 10;
  localparam int unsigned PAGE_PROGRAM_US    = 1500;
  localparam int unsigned BLOCK_ERASE_US     = 10000;
  localparam int unsigned RESET_READ_US      = 5;
  localparam int unsigned RESET_PROGRAM_US   = 10;
  localparam int unsigned RESET_ERASE_US     = 500;
  localparam int unsigned CYC_PER_US         = 1000 / CLK_PERIOD_NS;

  localparam int unsigned ADDR_CYCLES           = 3;
  localparam int unsigned PARTIAL_PROGRAM_LIMIT = 10;
  localparam int unsigned PAGE_BYTES            = 512;
  localparam int unsigned SPARE_BYTES           = 16;

  // Command bytes
  localparam logic [7:0] CMD_PROGRAM_CONFIRM = 8'h10;
  localparam logic [7:0] CMD_ERASE_CONFIRM   = 8'hd0;
  localparam logic [7:0] CMD_RESET           = 8'hff;

  // Operation the user requests
  typedef enum logic [2:0] {
    NFH_OP_READ    = 3'h0,
    NFH_OP_PROGRAM = 3'h1,
    NFH_OP_ERASE   = 3'h2,
    NFH_OP_RESET   = 3'h3,
    NFH_OP_CMD     = 3'h4
  } nfh_op_t;

  typedef struct packed {
    nfh_op_t     op;
    logic [7:0]  cmd;
    logic [7:0]  cmd2;
    logic [23:0] addr;
    logic [9:0]  len;
  } nfh_req_t;

  // Pin side bundle, strobes as driven
  typedef struct packed {
    logic       cmd_latch;
    logic       addr_latch;
    logic       chip_sel_n;
    logic       write_strobe_n;
    logic       output_strobe_n;
    logic       spare_area_disable;
    logic       program_lock_n;
  } nfh_pins_t;
endpackage

// ---- src/nfh_timer.sv ----
`timescale 1ns/1ps
module nfh_timer #(
  parameter int unsigned W = 24
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         load,
  input  wire logic [W-1:0] count,
  output logic              done
);
  logic [W-1:0] cnt_q;

  always_ff @(posedge clk)
    if (!rstn)
      cnt_q <= '0;
    else if (load)
      cnt_q <= count;
    else if (cnt_q != '0)
      cnt_q <= cnt_q - 1'b1;

  assign done = (cnt_q == '0) && !load;
endmodule

// ---- src/nfh_host.sv ----
`timescale 1ns/1ps
module nfh_host
  import nfh_pkg::*;
#(
  parameter int unsigned FETCH_CYC   = ARRAY_FETCH_US * CYC_PER_US,
  parameter int unsigned PROGRAM_CYC = PAGE_PROGRAM_US * CYC_PER_US,
  parameter int unsigned ERASE_CYC   = BLOCK_ERASE_US * CYC_PER_US,
  parameter int unsigned RST_CYC     = RESET_ERASE_US * CYC_PER_US
) (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       req_valid,
  output logic            req_ready,
  input  nfh_req_t        req,
  input  wire logic [7:0] wr_data,
  output logic            wr_take,
  output logic [7:0]      rd_data,
  output logic            rd_valid,
  output logic            done,
  output logic            timeout,
  output logic            refused,
  input  wire logic       spare_off,
  input  wire logic       lock_release,
  output nfh_pins_t       pins,
  input  wire logic [7:0] io_in,
  output logic [7:0]      io_out,
  output logic            io_oe,
  input  wire logic       ready_busy
);
  typedef enum logic [8:0] {
    S_IDLE  = 9'h001,
    S_CMD   = 9'h002,
    S_ADDR  = 9'h004,
    S_WDATA = 9'h008,
    S_CMD2  = 9'h010,
    S_BUSY  = 9'h020,
    S_RDATA = 9'h040,
    S_DESEL = 9'h080,
    S_DONE  = 9'h100
  } nfh_state_t;

  nfh_state_t  st_q, st_d;
  nfh_req_t    r_q;
  logic [1:0]  rb_sync_q;
  logic [1:0]  acnt_q;
  logic [9:0]  bcnt_q;
  logic [2:0]  ph_q;
  logic [3:0]  pp_cnt_q;
  logic [23:0] pp_page_q;
  logic        wdrive_q, rdrive_q, cs_n_q, cl_q, al_q, oe_q;
  logic [7:0]  io_q;
  logic        tmr_load, tmr_done, wait_load, wait_done;
  logic [23:0] tmr_count;

  ////////////////////////////////////////////////////////////////
  // Decode
  wire rb_ready   = rb_sync_q[1];
  wire is_write   = (r_q.op == NFH_OP_PROGRAM) || (r_q.op == NFH_OP_ERASE);
  wire locked     = is_write && !lock_release;
  wire page_same  = (req.addr[23:8] == pp_page_q[23:8]);
  wire pp_over    = (req.op == NFH_OP_PROGRAM) && page_same
                    && (pp_cnt_q == 4'(PARTIAL_PROGRAM_LIMIT));
  wire [9:0] page_len = spare_off ? 10'(PAGE_BYTES) : 10'(PAGE_BYTES + SPARE_BYTES);
  wire [9:0] xfer_len = (r_q.len == '0 || r_q.len > page_len) ? page_len : r_q.len;
  wire we_phase_end   = wdrive_q ? (ph_q == 3'(WE_LOW_CYC - 1)) : (ph_q == 3'(WE_HIGH_CYC));
  wire we_rise        = wdrive_q && we_phase_end;
  wire os_phase_end   = rdrive_q ? (ph_q == 3'(OS_LOW_CYC - 1)) : (ph_q == 3'(OS_HIGH_CYC));
  wire os_rise        = rdrive_q && os_phase_end;
  wire last_byte      = (bcnt_q == xfer_len - 10'h001);
  wire strobing       = (st_q == S_CMD) || (st_q == S_ADDR) || (st_q == S_WDATA) || (st_q == S_CMD2);
  wire [7:0] wbyte    = (st_q == S_ADDR) ? r_q.addr[8*acnt_q +: 8]
                      : (st_q == S_WDATA) ? wr_data
                      : (st_q == S_CMD2) ? r_q.cmd2 : r_q.cmd;

  assign tmr_count = (r_q.op == NFH_OP_READ) ? 24'(FETCH_CYC)
                   : (r_q.op == NFH_OP_PROGRAM) ? 24'(PROGRAM_CYC)
                   : (r_q.op == NFH_OP_ERASE) ? 24'(ERASE_CYC)
                   : 24'(RST_CYC);
  assign tmr_load  = (st_d == S_BUSY) && (st_q != S_BUSY);
  assign wait_load = tmr_load;

  nfh_timer #(.W(24)) u_limit (
    .clk   (clk),
    .rstn  (rstn),
    .load  (tmr_load),
    .count (tmr_count),
    .done  (tmr_done)
  );
  nfh_timer #(.W(24)) u_settle (
    .clk   (clk),
    .rstn  (rstn),
    .load  (wait_load),
    .count (24'(BUSY_WAIT_CYC)),
    .done  (wait_done)
  );

  ////////////////////////////////////////////////////////////////
  // Sequencer
  always_comb
  begin
    st_d = st_q;
    unique case (st_q)
      S_IDLE:  if (req_valid && !pp_over) st_d = S_CMD;
      S_CMD:   if (we_rise) st_d = (r_q.op == NFH_OP_RESET) ? S_BUSY
                                 : (r_q.op == NFH_OP_CMD) ? S_DONE : S_ADDR;
      S_ADDR:  if (we_rise && acnt_q == 2'(ADDR_CYCLES - 1))
                 st_d = (r_q.op == NFH_OP_PROGRAM) ? S_WDATA
                      : (r_q.op == NFH_OP_ERASE) ? S_CMD2 : S_BUSY;
      S_WDATA: if (we_rise && last_byte) st_d = S_CMD2;
      S_CMD2:  if (we_rise) st_d = S_BUSY;
      // Limit run out: give up, never strobe a busy device
      S_BUSY:  if (wait_done && rb_ready)
                 st_d = (r_q.op != NFH_OP_READ) ? S_DONE
                      : (ph_q >= 3'(WHR_CYC)) ? S_RDATA : S_BUSY;
               else if (tmr_done)
                 st_d = S_DONE;
      S_RDATA: if (os_rise && last_byte) st_d = S_DESEL;
      S_DESEL: if (ph_q == 3'(CEH_CYC)) st_d = S_DONE;
      S_DONE:  st_d = S_IDLE;
      default: st_d = S_IDLE;
    endcase
  end

  always_ff @(posedge clk)
    if (!rstn)
      rb_sync_q <= 2'h3;
    else
      rb_sync_q <= {rb_sync_q[0], ready_busy};

  always_ff @(posedge clk)
    if (!rstn)
    begin
      st_q <= S_IDLE; r_q <= '0; acnt_q <= '0; bcnt_q <= '0; ph_q <= '0;
      wdrive_q <= 1'b0; rdrive_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      if (st_q == S_IDLE && req_valid) r_q <= req;
      if (st_d != st_q) ph_q <= '0;
      else if (strobing && we_phase_end) ph_q <= '0;
      else if (st_q == S_RDATA && os_phase_end) ph_q <= '0;
      else if (ph_q != 3'h7) ph_q <= ph_q + 3'h1;
      wdrive_q <= strobing && (st_d == st_q || !we_rise) ? (we_phase_end ? !wdrive_q : wdrive_q) : 1'b0;
      rdrive_q <= (st_q == S_RDATA && st_d == S_RDATA) ? (os_phase_end ? !rdrive_q : rdrive_q)
                : (st_d == S_RDATA);
      if (st_q == S_ADDR && we_rise) acnt_q <= acnt_q + 2'h1;
      else if (st_q != S_ADDR) acnt_q <= '0;
      if ((st_q == S_WDATA && we_rise) || (st_q == S_RDATA && os_rise)) bcnt_q <= bcnt_q + 10'h001;
      else if (st_q == S_IDLE) bcnt_q <= '0;
    end

  // Partial program bookkeeping for the last programmed page only; erase of that block clears it
  always_ff @(posedge clk)
    if (!rstn)
    begin
      pp_cnt_q <= '0; pp_page_q <= '0;
    end
    else if (st_q == S_IDLE && req_valid && !pp_over)
    begin
      if (req.op == NFH_OP_PROGRAM)
      begin
        pp_page_q <= req.addr;
        pp_cnt_q  <= page_same ? pp_cnt_q + 4'h1 : 4'h1;
      end
      else if (req.op == NFH_OP_ERASE && req.addr[23:13] == pp_page_q[23:13])
        pp_cnt_q <= '0;
    end

  ////////////////////////////////////////////////////////////////
  // Pins and user outputs, registered except spare_area_disable, program_lock_n, req_ready and wr_take
  always_ff @(posedge clk)
    if (!rstn)
    begin
      cs_n_q <= 1'b1; cl_q <= 1'b0; al_q <= 1'b0; io_q <= '0; oe_q <= 1'b0;
      rd_data <= '0; rd_valid <= 1'b0; done <= 1'b0; timeout <= 1'b0; refused <= 1'b0;
    end
    else
    begin
      // Latches follow the current state, so they outlast the last strobe rise; select follows the next state
      cs_n_q   <= (st_d == S_IDLE) || (st_d == S_DESEL) || (st_q == S_DESEL);
      cl_q     <= (st_q == S_CMD) || (st_q == S_CMD2);
      al_q     <= (st_q == S_ADDR);
      oe_q     <= strobing && st_d != S_BUSY && st_d != S_DONE;
      io_q     <= wbyte;
      rd_valid <= (st_q == S_RDATA) && os_rise;
      if ((st_q == S_RDATA) && os_rise) rd_data <= io_in;
      done     <= (st_d == S_DONE) && (st_q != S_DONE);
      timeout  <= (st_q == S_BUSY) && tmr_done && !rb_ready;
      refused  <= (st_q == S_IDLE) && req_valid && pp_over;
    end

  assign pins.cmd_latch          = cl_q;
  assign pins.addr_latch         = al_q;
  assign pins.chip_sel_n         = cs_n_q;
  assign pins.write_strobe_n     = !wdrive_q;
  assign pins.output_strobe_n    = !rdrive_q;
  assign pins.spare_area_disable = spare_off;
  assign pins.program_lock_n     = is_write && !locked && (st_q != S_IDLE);
  assign io_out    = io_q;
  assign io_oe     = oe_q;
  assign req_ready = (st_q == S_IDLE);
  assign wr_take   = (st_q == S_WDATA) && we_rise;

  ////////////////////////////////////////////////////////////////
  // Checks
  cs_high_end_a: assert property (@(posedge clk) disable iff (!rstn)
    (st_q == S_RDATA && st_d == S_DESEL) |=> pins.chip_sel_n [*4])
    else $error("chip select not held high after last read");
  addr_three_a: assert property (@(posedge clk) disable iff (!rstn)
    (st_q == S_ADDR && st_d != S_ADDR) |-> acnt_q == 2'h2)
    else $error("address sequence not three strobes");
  cmd_latch_a: assert property (@(posedge clk) disable iff (!rstn)
    (st_q == S_CMD && wdrive_q) |-> pins.cmd_latch && !pins.addr_latch && !pins.chip_sel_n)
    else $error("command strobe without command latch");
  pp_limit_a: assert property (@(posedge clk) disable iff (!rstn)
    pp_cnt_q <= 4'(PARTIAL_PROGRAM_LIMIT))
    else $error("partial program count over limit");
  no_strobe_busy_a: assert property (@(posedge clk) disable iff (!rstn)
    (st_q == S_BUSY) |-> !wdrive_q && !rdrive_q)
    else $error("strobe while device busy");
  lock_write_a: assert property (@(posedge clk) disable iff (!rstn)
    (!lock_release) |-> !pins.program_lock_n)
    else $error("program lock released while locked");
  read_latch_a: assert property (@(posedge clk) disable iff (!rstn)
    rdrive_q |-> !pins.cmd_latch && !pins.addr_latch && !pins.chip_sel_n && pins.write_strobe_n)
    else $error("output strobe with wrong latch levels");
  data_lock_a: assert property (@(posedge clk) disable iff (!rstn)
    (st_q == S_WDATA && wdrive_q) |-> !pins.cmd_latch && !pins.addr_latch
      && (pins.program_lock_n == lock_release))
    else $error("data strobe with wrong levels");
endmodule

// ---- testbench/nfh_dev_model.sv ----
`timescale 1ns/1ps
module nfh_dev_model
  import nfh_pkg::*;
#(
  parameter int FETCH_CYC = 20,
  parameter int PROG_CYC  = 40,
  parameter int ERASE_CYC = 50,
  parameter int RST_CYC   = 8
) (
  input  wire logic       clk,
  input  wire logic       stuck,
  input  nfh_pins_t       pins,
  input  wire logic [7:0] io_out,
  output logic [7:0]      io_in,
  output logic            ready_busy
);
  logic [7:0]  mem [int];
  logic [7:0]  pend [int];
  logic [7:0]  cmd_q = 8'hff;
  logic [23:0] addr_q = '0;
  int          acnt = 0;
  int          col = 0;
  int          busy = 0;
  int          plen;

  // Open drain with pull-up, so ready whenever idle
  assign ready_busy = (busy == 0);
  assign plen = pins.spare_area_disable ? PAGE_BYTES : PAGE_BYTES + SPARE_BYTES;
  initial io_in = 8'h5a;

  function automatic int key(int c);
    return {addr_q[23:8], c[9:0]};
  endfunction

  // Stuck lets the bench hold the device busy for ever
  always @(posedge clk)
    if (busy > 0 && !stuck)
      busy = busy - 1;
  //////////////////////////////
  always @(posedge pins.write_strobe_n)
    if (!pins.chip_sel_n && pins.cmd_latch && io_out == CMD_RESET)
      busy = RST_CYC;
    else if (!pins.chip_sel_n && busy == 0)
    begin
      if (pins.cmd_latch)
      begin
        cmd_q = io_out;
        acnt = 0;
        if (io_out == CMD_PROGRAM_CONFIRM && pins.program_lock_n)
        begin
          foreach (pend[k]) mem[k] = pend[k];
          busy = PROG_CYC;
        end
        if (io_out == CMD_ERASE_CONFIRM && pins.program_lock_n)
        begin
          foreach (mem[k]) if (k[25:15] == addr_q[23:13]) mem[k] = 8'hff;
          busy = ERASE_CYC;
        end
        pend.delete();
      end
      else if (pins.addr_latch)
      begin
        addr_q[8*acnt +: 8] = io_out;
        acnt++;
        col = addr_q[7:0];
        if (acnt == ADDR_CYCLES && cmd_q != 8'h80 && cmd_q != 8'h60)
          busy = FETCH_CYC;
      end
      else if (pins.program_lock_n && col < plen)
      begin
        pend[key(col)] = io_out;
        col++;
      end
    end
  //////////////////////////////
  always @(negedge pins.output_strobe_n)
    if (!pins.chip_sel_n && busy == 0 && !pins.cmd_latch && !pins.addr_latch)
    begin
      io_in = mem.exists(key(col)) ? mem[key(col)] : 8'hff;
      col++;
      if (col >= plen)
      begin
        col = 0;
        addr_q[23:8] = addr_q[23:8] + 16'h1;
        busy = FETCH_CYC;
      end
    end
  // No pull on the data lines: released value is the inverse
  always @(posedge pins.output_strobe_n)
    io_in = ~io_in;
  always @(posedge pins.chip_sel_n)
    if (busy > 0 && cmd_q != CMD_PROGRAM_CONFIRM && cmd_q != CMD_ERASE_CONFIRM)
      busy = 1;
endmodule

// ---- testbench/test_nfh_host.sv ----
`timescale 1ns/1ps
module test_nfh_host;
  import nfh_pkg::*;
  logic       clk, rstn, req_valid, stuck;
  logic       spare_off, lock_release;
  logic       req_ready, wr_take, rd_valid, done, timeout, refused, io_oe, ready_busy;
  logic [7:0] wr_data, rd_data, io_in, io_out;
  logic [7:0] wb [0:15];
  logic [7:0] exp_q [$];
  nfh_req_t   req;
  nfh_pins_t  pins;
  int         widx = 0, got = 0, rd_cnt = 0, fail_count = 0, num_checks = 0;
  int         seed = 32'hbc7c1acc;

  always #12.5 clk = ~clk;
  assign wr_data = wb[widx[3:0]];

  // Small limits keep the run short
  nfh_host #(.FETCH_CYC(64), .PROGRAM_CYC(128), .ERASE_CYC(128), .RST_CYC(64)) uut (
    .clk(clk), .rstn(rstn), .req_valid(req_valid), .req_ready(req_ready), .req(req),
    .wr_data(wr_data), .wr_take(wr_take), .rd_data(rd_data), .rd_valid(rd_valid), .done(done),
    .timeout(timeout), .refused(refused), .spare_off(spare_off), .lock_release(lock_release),
    .pins(pins), .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .ready_busy(ready_busy));
  nfh_dev_model dev (.clk(clk), .stuck(stuck), .pins(pins), .io_out(io_out), .io_in(io_in),
    .ready_busy(ready_busy));
  //////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Result codes: 1 done, 2 refused, 3 timeout
  task automatic do_op(input nfh_op_t op, input logic [7:0] c1, input logic [7:0] c2,
                       input logic [23:0] a, input logic [9:0] n, input int want);
    int i;
    i = 0;
    got = 0;
    widx = 0;
    rd_cnt = 0;
    req = '{op: op, cmd: c1, cmd2: c2, addr: a, len: n};
    req_valid = 1'b1;
    @(posedge clk);
    while (req_ready !== 1'b1 && i < 100)
    begin
      @(posedge clk);
      i++;
    end
    #1 req_valid = 1'b0;
    while (got == 0 && i < 4000)
    begin
      @(posedge clk);
      got = (timeout === 1'b1) ? 3 : (refused === 1'b1) ? 2 : (done === 1'b1) ? 1 : 0;
      i++;
    end
    #1 check(got, want);
    $display("op %0d at %h ended with %0d", op, a, got);
  endtask
  //////////////////////////////
  always @(posedge clk)
    if (wr_take === 1'b1)
      #1 widx++;

  always @(posedge clk)
    if (rd_valid === 1'b1)
    begin
      rd_cnt++;
      check(io_oe, 1'b0);
      if (exp_q.size() > 0)
        check(rd_data, exp_q.pop_front());
      else
        check(rd_data, 9'h100);
    end

  initial
  begin
    #(40000 * CLK_PERIOD_NS);
    fail_count++;
    test_done();
  end

  initial
  begin
    clk = 1'b0;
    rstn = 1'b0;
    req_valid = 1'b0;
    stuck = 1'b0;
    spare_off = 1'b0;
    lock_release = 1'b1;
    req = '0;
    for (int i = 0; i < 16; i++)
      wb[i] = 8'($random(seed));
    repeat (3) @(posedge clk);
    #1 rstn = 1'b1;
    do_op(NFH_OP_PROGRAM, 8'h80, CMD_PROGRAM_CONFIRM, 24'h000000, 10'd8, 1);
    for (int i = 0; i < 8; i++)
      exp_q.push_back(wb[i]);
    do_op(NFH_OP_READ, 8'h00, 8'h00, 24'h000000, 10'd8, 1);
    check(rd_cnt, 8);
    // Locked program must leave the page untouched
    lock_release = 1'b0;
    for (int i = 0; i < 8; i++)
      wb[i] = ~wb[i];
    do_op(NFH_OP_PROGRAM, 8'h80, CMD_PROGRAM_CONFIRM, 24'h000000, 10'd8, 1);
    for (int i = 0; i < 8; i++)
      exp_q.push_back(~wb[i]);
    do_op(NFH_OP_READ, 8'h00, 8'h00, 24'h000000, 10'd8, 1);
    lock_release = 1'b1;
    for (int i = 0; i <= PARTIAL_PROGRAM_LIMIT; i++)
      do_op(NFH_OP_PROGRAM, 8'h80, CMD_PROGRAM_CONFIRM, 24'h004000, 10'd1, i < 10 ? 1 : 2);
    do_op(NFH_OP_ERASE, 8'h60, CMD_ERASE_CONFIRM, 24'h004000, 10'd0, 1);
    do_op(NFH_OP_PROGRAM, 8'h80, CMD_PROGRAM_CONFIRM, 24'h004001, 10'd1, 1);
    exp_q.push_back(8'hff);
    exp_q.push_back(wb[0]);
    do_op(NFH_OP_READ, 8'h00, 8'h00, 24'h004000, 10'd2, 1);
    for (int sp = 0; sp < 2; sp++)
    begin
      spare_off = sp[0];
      repeat (PAGE_BYTES + SPARE_BYTES * (1 - sp)) exp_q.push_back(8'hff);
      do_op(NFH_OP_READ, 8'h00, 8'h00, 24'h008000, 10'd0, 1);
      check(rd_cnt, PAGE_BYTES + SPARE_BYTES * (1 - sp));
    end
    spare_off = 1'b0;
    // Device held busy: host must give up by its limit
    stuck = 1'b1;
    exp_q.push_back(~wb[0]);
    do_op(NFH_OP_READ, 8'h00, 8'h00, 24'h000000, 10'd1, 3);
    stuck = 1'b0;
    repeat (200) @(posedge clk);
    // A timed-out read must not strobe a busy device
    #1 check(exp_q.size(), 1);
    exp_q.delete();
    do_op(NFH_OP_CMD, 8'h00, 8'h00, 24'h000000, 10'd0, 1);
    do_op(NFH_OP_RESET, CMD_RESET, 8'h00, 24'h000000, 10'd0, 1);
    test_done();
  end
endmodule
